// ===== verilog/led_blink_pkg.sv
// constants, types and field layout of the led digit plane blink controller
// How it works
// - two planes of eight digit bytes, written by serial frames while scanning reads
// - each digit owns a primary byte and an alternate byte, two bits per segment
// - one write targets primary plane, alternate plane, or both with same data
// - configuration at 0x04: clear D5, sync D4, blink enable D3, rate D2, run D0
// - run bit zero means shutdown, one means normal operation
// - rate zero blinks 1s on 1s off, one blinks 0.5s, at 4MHz multiplex clock
// - blink enable bit zero disables blinking, one enables it
// - sync bit set clears blink timing counters when chip select rises
// - clear bit set clears both digit planes when chip select rises
// - display test at 0x07: D0 one selects test mode, other bits ignored
// - scan limit at 0x03: D2-D0 give N, digits 0 to N are scanned
// - blink disabled shows primary plane only
// - blink enabled shows primary and alternate plane on alternate blink phases
// - once enabled, plane alternation continues with no further commands
// - blink period comes from multiplex clock and rate bit, one rate for all
// - test mode lights all leds, eight digits, 7/16 duty, registers untouched
// - sync also clears the divider chain and restarts the multiplex sequence
package led_blink_pkg;

   // command address codes
   localparam logic [7:0] ADDR_SCAN_LIMIT = 8'h03;
   localparam logic [7:0] ADDR_CONFIG     = 8'h04;
   localparam logic [7:0] ADDR_TEST       = 8'h07;

   // digit address layout: bit 5 primary, bit 6 alternate, 2:0 digit
   localparam int DIG_PRIMARY_BIT = 5;
   localparam int DIG_ALT_BIT     = 6;

   // configuration field positions
   localparam int CFG_CLEAR_BIT = 5;
   localparam int CFG_SYNC_BIT  = 4;
   localparam int CFG_BLINK_BIT = 3;
   localparam int CFG_FAST_BIT  = 2;
   localparam int CFG_RUN_BIT   = 0;
   localparam int TEST_BIT      = 0;

   // reset values
   localparam logic [2:0] SCAN_LIMIT_RST = 3'h4;
   localparam logic       TEST_RST       = 1'b0;
   localparam logic [7:0] DIGIT_RST      = 8'h00;

   // serial frame length in bits
   localparam logic [4:0] FRAME_BITS = 5'h10;

   // timing, counted in multiplex clock rising edges
   localparam int OSC_HZ        = 4000000;
   localparam int BLINK_SLOW_MS = 1000;
   localparam int BLINK_SLOW_TICKS_DEF = OSC_HZ / 1000 * BLINK_SLOW_MS;
   localparam int DIGIT_SLOT_US = 200;
   localparam int DIGIT_TICKS   = OSC_HZ / 1000000 * DIGIT_SLOT_US;
   localparam int TEST_ON_TICKS   = DIGIT_TICKS * 7 / 16;
   localparam int NORMAL_ON_TICKS = DIGIT_TICKS * 15 / 16;

   typedef struct packed {
      logic clear_data;
      logic sync;
      logic blink_en;
      logic fast;
      logic run;
   } cfg_t;

   localparam cfg_t CFG_RST = '0;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } frame_t;

   typedef logic [7:0][7:0] plane_t;

endpackage

// ===== verilog/led_digit_plane_blink_control.sv
// led digit plane storage, serial command port, multiplex scan and blink
`timescale 1ns/10ps
module led_digit_plane_blink_control #(
   parameter int BLINK_SLOW_TICKS = led_blink_pkg::BLINK_SLOW_TICKS_DEF
) (
   // clock and reset
   input  wire logic       MCLK,
   input  wire logic       SYS_RST,
   // serial command port
   input  wire logic       CS_N,
   input  wire logic       SCLK,
   input  wire logic       DIN,
   // multiplex clock
   input  wire logic       MUX_CLK_IN,
   // led drive
   output logic [7:0]      SEG_OUT,
   output logic [7:0]      DIGIT_OUT,
   // state
   output logic            BLINK_PHASE,
   output logic [2:0]      SCAN_DIGIT
);
   import led_blink_pkg::*;

   logic                   cs_n_q_r;
   logic                   sclk_q_r;
   logic                   osc_q_r;
   logic                   sclk_rise;
   logic                   cs_rise;
   logic                   osc_tick;

   led_blink_pkg::frame_t  frame_r;
   logic [4:0]             bits_r;
   logic                   commit;
   logic                   cfg_wr;
   logic                   digit_wr;
   logic                   sync_cmd;
   logic                   clear_cmd;

   logic [2:0]             scan_limit_r;
   led_blink_pkg::cfg_t    cfg_r;
   logic                   test_r;
   led_blink_pkg::plane_t  primary_plane_r;
   led_blink_pkg::plane_t  alternate_plane_r;

   logic [9:0]             slot_cnt_r;
   logic [2:0]             idx_r;
   logic [21:0]            blink_cnt_r;
   logic                   phase_r;
   logic                   slot_end;
   logic [2:0]             last_digit;
   logic [21:0]            blink_last;
   logic                   blink_wrap;
   logic [7:0]             shown_data;

   // edge detection of the pins, all synchronous to MCLK
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         cs_n_q_r <= 1'b1;
         sclk_q_r <= 1'b0;
         osc_q_r  <= 1'b0;
      end else begin
         cs_n_q_r <= CS_N;
         sclk_q_r <= SCLK;
         osc_q_r  <= MUX_CLK_IN;
      end
   end

   assign sclk_rise = SCLK & ~sclk_q_r & ~CS_N;
   assign cs_rise   = CS_N & ~cs_n_q_r;
   assign osc_tick  = MUX_CLK_IN & ~osc_q_r;

   // shift in msb first; the last sixteen bits of a frame count
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         frame_r <= '0;
         bits_r  <= 5'h00;
      end else if (cs_rise) begin
         bits_r <= 5'h00;
      end else if (sclk_rise) begin
         frame_r <= {frame_r[14:0], DIN};
         if (bits_r != FRAME_BITS) begin
            bits_r <= bits_r + 5'h01;
         end
      end
   end

   // command acts when chip select rises after a full frame
   assign commit    = cs_rise && (bits_r == FRAME_BITS);
   assign cfg_wr    = commit && (frame_r.addr == ADDR_CONFIG);
   assign digit_wr  = commit && !frame_r.addr[7] && (frame_r.addr[4:3] == 2'h0);
   assign sync_cmd  = cfg_wr && frame_r.data[CFG_SYNC_BIT];
   assign clear_cmd = cfg_wr && frame_r.data[CFG_CLEAR_BIT];

   // control registers
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         scan_limit_r <= SCAN_LIMIT_RST;
      end else if (commit && frame_r.addr == ADDR_SCAN_LIMIT) begin
         scan_limit_r <= frame_r.data[2:0];
      end
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         cfg_r <= CFG_RST;
      end else if (cfg_wr) begin
         cfg_r.clear_data <= frame_r.data[CFG_CLEAR_BIT];
         cfg_r.sync       <= frame_r.data[CFG_SYNC_BIT];
         cfg_r.blink_en   <= frame_r.data[CFG_BLINK_BIT];
         cfg_r.fast       <= frame_r.data[CFG_FAST_BIT];
         cfg_r.run        <= frame_r.data[CFG_RUN_BIT];
      end
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         test_r <= TEST_RST;
      end else if (commit && frame_r.addr == ADDR_TEST) begin
         test_r <= frame_r.data[TEST_BIT];
      end
   end

   // two digit planes; writes never stall the scan reads
   generate
      for (genvar g = 0; g < 8; g++) begin : g_digit
         always_ff @(posedge MCLK) begin
            if (SYS_RST || clear_cmd) begin
               primary_plane_r[g]   <= DIGIT_RST;
               alternate_plane_r[g] <= DIGIT_RST;
            end else if (digit_wr && frame_r.addr[2:0] == 3'(g)) begin
               if (frame_r.addr[DIG_PRIMARY_BIT]) begin
                  primary_plane_r[g] <= frame_r.data;
               end
               if (frame_r.addr[DIG_ALT_BIT]) begin
                  alternate_plane_r[g] <= frame_r.data;
               end
            end
         end
      end
   endgenerate

   // multiplex scan: test mode always scans eight digits
   assign slot_end   = osc_tick && (slot_cnt_r == 10'(DIGIT_TICKS - 1));
   assign last_digit = test_r ? 3'h7 : scan_limit_r;

   always_ff @(posedge MCLK) begin
      if (SYS_RST || sync_cmd) begin
         slot_cnt_r <= 10'h000;
         idx_r      <= 3'h0;
      end else if (slot_end) begin
         slot_cnt_r <= 10'h000;
         if (idx_r >= last_digit) begin
            idx_r <= 3'h0;
         end else begin
            idx_r <= idx_r + 3'h1;
         end
      end else if (osc_tick) begin
         slot_cnt_r <= slot_cnt_r + 10'h001;
      end
   end

   // blink divider runs free from the multiplex clock
   assign blink_last = cfg_r.fast ? 22'(BLINK_SLOW_TICKS / 2 - 1)
                                  : 22'(BLINK_SLOW_TICKS - 1);
   assign blink_wrap = osc_tick && (blink_cnt_r >= blink_last);

   always_ff @(posedge MCLK) begin
      if (SYS_RST || sync_cmd) begin
         blink_cnt_r <= 22'h000000;
         phase_r     <= 1'b0;
      end else if (blink_wrap) begin
         blink_cnt_r <= 22'h000000;
         phase_r     <= ~phase_r;
      end else if (osc_tick) begin
         blink_cnt_r <= blink_cnt_r + 22'h000001;
      end
   end

   // plane choice: alternate only on the second blink phase
   assign shown_data = (cfg_r.blink_en && phase_r) ? alternate_plane_r[idx_r]
                                                   : primary_plane_r[idx_r];

   // led drive; test overrides shutdown, registers stay untouched
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         SEG_OUT   <= 8'h00;
         DIGIT_OUT <= 8'h00;
      end else if (test_r) begin
         if (slot_cnt_r < 10'(TEST_ON_TICKS)) begin
            SEG_OUT   <= 8'hff;
            DIGIT_OUT <= 8'h01 << idx_r;
         end else begin
            SEG_OUT   <= 8'h00;
            DIGIT_OUT <= 8'h00;
         end
      end else if (!cfg_r.run) begin
         SEG_OUT   <= 8'h00;
         DIGIT_OUT <= 8'h00;
      end else if (slot_cnt_r < 10'(NORMAL_ON_TICKS)) begin
         SEG_OUT   <= shown_data;
         DIGIT_OUT <= 8'h01 << idx_r;
      end else begin
         SEG_OUT   <= 8'h00;
         DIGIT_OUT <= 8'h00;
      end
   end

   assign BLINK_PHASE = phase_r;
   assign SCAN_DIGIT  = idx_r;

   // checks
   a_shutdown_blanks: assert property (@(posedge MCLK) disable iff (SYS_RST)
      $past(!cfg_r.run && !test_r) |-> (SEG_OUT == 8'h00 && DIGIT_OUT == 8'h00))
      else $error("shutdown did not blank the display");

   a_test_all_on: assert property (@(posedge MCLK) disable iff (SYS_RST)
      $past(test_r && slot_cnt_r < 10'(TEST_ON_TICKS)) |-> SEG_OUT == 8'hff)
      else $error("display test did not light all segments");

   a_test_duty_off: assert property (@(posedge MCLK) disable iff (SYS_RST)
      $past(test_r && slot_cnt_r >= 10'(TEST_ON_TICKS)) |-> SEG_OUT == 8'h00)
      else $error("display test exceeded its duty");

   a_blink_off_primary: assert property (@(posedge MCLK)
      disable iff (SYS_RST)
      $past(cfg_r.run && !test_r && !cfg_r.blink_en
            && slot_cnt_r < 10'(NORMAL_ON_TICKS))
      |-> SEG_OUT == $past(primary_plane_r[idx_r]))
      else $error("primary plane not shown with blink off");

   a_blink_alt_phase: assert property (@(posedge MCLK) disable iff (SYS_RST)
      $past(cfg_r.run && !test_r && cfg_r.blink_en && phase_r
            && slot_cnt_r < 10'(NORMAL_ON_TICKS))
      |-> SEG_OUT == $past(alternate_plane_r[idx_r]))
      else $error("alternate plane not shown on blink phase");

   a_phase_toggle: assert property (@(posedge MCLK) disable iff (SYS_RST)
      $changed(phase_r) |-> ($past(blink_wrap) || $past(sync_cmd)))
      else $error("blink phase moved without divider wrap");

   a_sync_clears: assert property (@(posedge MCLK) disable iff (SYS_RST)
      sync_cmd |=> (blink_cnt_r == 22'h000000 && slot_cnt_r == 10'h000
                    && idx_r == 3'h0 && !phase_r))
      else $error("sync did not clear the timing chain");

   a_clear_planes: assert property (@(posedge MCLK) disable iff (SYS_RST)
      clear_cmd |=> (primary_plane_r == '0 && alternate_plane_r == '0))
      else $error("clear did not empty both planes");

   a_alt_only_write: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (digit_wr && frame_r.addr[6:5] == 2'h2)
      |=> (alternate_plane_r[$past(frame_r.addr[2:0])] == $past(frame_r.data)
           && primary_plane_r == $past(primary_plane_r)))
      else $error("alternate plane write went wrong");

   a_scan_wrap: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (slot_end && !test_r && !sync_cmd && idx_r >= scan_limit_r)
      |=> idx_r == 3'h0)
      else $error("scan passed the scan limit");

   a_test_eight: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (slot_end && test_r && !sync_cmd && idx_r == 3'h6) |=> idx_r == 3'h7)
      else $error("test mode did not scan eight digits");

   a_limit_write: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (commit && frame_r.addr == ADDR_SCAN_LIMIT)
      |=> scan_limit_r == $past(frame_r.data[2:0]))
      else $error("scan limit not taken from frame");

   // outputs come out of reset blanked, timing chain at its start
   a_reset_blank: assert property (@(posedge MCLK)
      $past(SYS_RST) |-> (SEG_OUT == 8'h00 && DIGIT_OUT == 8'h00
                          && !phase_r && idx_r == 3'h0))
      else $error("outputs not blank after reset");

   a_digit_onehot: assert property (@(posedge MCLK)
      disable iff (SYS_RST)
      (DIGIT_OUT == 8'h00 || $onehot(DIGIT_OUT)))
      else $error("more than one digit selected");

   a_digit_select: assert property (@(posedge MCLK)
      disable iff (SYS_RST)
      $past(cfg_r.run && !test_r && slot_cnt_r < 10'(NORMAL_ON_TICKS))
      |-> DIGIT_OUT == (8'h01 << $past(idx_r)))
      else $error("lit digit does not match scan index");

   a_slot_gap: assert property (@(posedge MCLK)
      disable iff (SYS_RST)
      $past(!test_r && slot_cnt_r >= 10'(NORMAL_ON_TICKS))
      |-> (SEG_OUT == 8'h00 && DIGIT_OUT == 8'h00))
      else $error("digit not blanked at end of slot");

   a_blink_primary_phase: assert property (@(posedge MCLK)
      disable iff (SYS_RST)
      $past(cfg_r.run && !test_r && cfg_r.blink_en && !phase_r
            && slot_cnt_r < 10'(NORMAL_ON_TICKS))
      |-> SEG_OUT == $past(primary_plane_r[idx_r]))
      else $error("primary plane not shown on first phase");

   a_test_digit: assert property (@(posedge MCLK)
      disable iff (SYS_RST)
      $past(test_r && slot_cnt_r < 10'(TEST_ON_TICKS))
      |-> DIGIT_OUT == (8'h01 << $past(idx_r)))
      else $error("display test selected the wrong digit");

   a_primary_only_write: assert property (@(posedge MCLK)
      disable iff (SYS_RST)
      (digit_wr && frame_r.addr[6:5] == 2'h1)
      |=> (primary_plane_r[$past(frame_r.addr[2:0])] == $past(frame_r.data)
           && alternate_plane_r == $past(alternate_plane_r)))
      else $error("primary plane write went wrong");

   a_both_write: assert property (@(posedge MCLK)
      disable iff (SYS_RST)
      (digit_wr && frame_r.addr[6:5] == 2'h3)
      |=> (primary_plane_r[$past(frame_r.addr[2:0])] == $past(frame_r.data)
           && alternate_plane_r[$past(frame_r.addr[2:0])]
              == $past(frame_r.data)))
      else $error("dual plane write went wrong");

   a_planes_hold: assert property (@(posedge MCLK)
      disable iff (SYS_RST)
      (!digit_wr && !clear_cmd)
      |=> (primary_plane_r == $past(primary_plane_r)
           && alternate_plane_r == $past(alternate_plane_r)))
      else $error("digit planes changed without a write");

   a_cfg_capture: assert property (@(posedge MCLK)
      disable iff (SYS_RST)
      cfg_wr
      |=> (cfg_r.run == $past(frame_r.data[CFG_RUN_BIT])
           && cfg_r.fast == $past(frame_r.data[CFG_FAST_BIT])
           && cfg_r.blink_en == $past(frame_r.data[CFG_BLINK_BIT])))
      else $error("configuration fields not taken from frame");

   a_test_capture: assert property (@(posedge MCLK)
      disable iff (SYS_RST)
      (commit && frame_r.addr == ADDR_TEST)
      |=> test_r == $past(frame_r.data[TEST_BIT]))
      else $error("display test bit not taken from frame");

   // a frame cut short must leave the scan limit, configuration and test registers alone
   a_short_frame: assert property (@(posedge MCLK)
      disable iff (SYS_RST)
      (cs_rise && bits_r != FRAME_BITS)
      |=> (scan_limit_r == $past(scan_limit_r) && cfg_r == $past(cfg_r)
           && test_r == $past(test_r)))
      else $error("short frame changed a register");

   a_slot_bound: assert property (@(posedge MCLK)
      disable iff (SYS_RST)
      slot_cnt_r < 10'(DIGIT_TICKS))
      else $error("slot counter ran past the slot");

   a_blink_bound: assert property (@(posedge MCLK)
      disable iff (SYS_RST)
      blink_cnt_r <= 22'(BLINK_SLOW_TICKS - 1))
      else $error("blink counter ran past the slow period");

   a_phase_steady: assert property (@(posedge MCLK)
      disable iff (SYS_RST)
      (!blink_wrap && !sync_cmd) |=> phase_r == $past(phase_r))
      else $error("blink phase moved on its own");

endmodule

// ===== test/host_serial_model.sv
// host side serial master that sends address and data frames
`timescale 1ns/10ps
module host_serial_model (
   // clock
   input  wire logic mclk,
   // serial command lines
   output logic      cs_n,
   output logic      sclk,
   output logic      din
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din  = 1'b0;
   end

   // address byte then data byte in one low frame
   task automatic send(input logic [7:0] a, input logic [7:0] d);
      logic [15:0] w;
      w = {a, d};
      @(posedge mclk) cs_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         @(posedge mclk) din <= w[i];
         repeat (2) @(posedge mclk);
         sclk <= 1'b1;
         repeat (2) @(posedge mclk);
         sclk <= 1'b0;
      end
      // released data line must not keep the last bit
      @(posedge mclk) cs_n <= 1'b1;
      din <= ~din;
      repeat (3) @(posedge mclk);
   endtask
endmodule

// ===== test/tb_top.sv
// testbench for the led digit plane blink controller
`timescale 1ns/10ps
module tb_top;
   import led_blink_pkg::*;
   localparam int BLINK_T = 64;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
      logic [2:0] dig;
      logic [7:0] prim;
      logic [7:0] alt;
   } row_t;
   logic       MCLK = 1'b0;
   logic       SYS_RST = 1'b1;
   logic       MUX_CLK_IN = 1'b0;
   logic       CS_N, SCLK, DIN, BLINK_PHASE;
   logic [7:0] SEG_OUT, DIGIT_OUT;
   logic [2:0] SCAN_DIGIT;
   int         n_fail = 0;
   int         tests_run = 0;
   int         n;
   row_t       rows [4];

   always #5 MCLK = ~MCLK;
   always @(posedge MCLK) MUX_CLK_IN <= ~MUX_CLK_IN;

   host_serial_model host_serial_model_i (
      .mclk(MCLK), .cs_n(CS_N), .sclk(SCLK), .din(DIN));
   led_digit_plane_blink_control #(.BLINK_SLOW_TICKS(BLINK_T))
      led_digit_plane_blink_control_i (
      .MCLK(MCLK), .SYS_RST(SYS_RST), .CS_N(CS_N), .SCLK(SCLK), .DIN(DIN),
      .MUX_CLK_IN(MUX_CLK_IN), .SEG_OUT(SEG_OUT), .DIGIT_OUT(DIGIT_OUT),
      .BLINK_PHASE(BLINK_PHASE), .SCAN_DIGIT(SCAN_DIGIT));

   task automatic chk(input string nm, input logic [15:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // wait until a digit is lit in a phase for three settled cycles
   task automatic wait_for(input logic [7:0] dig, input logic ph);
      int h, k;
      h = 0;
      k = 0;
      while (h < 3 && k < 20000) begin
         @(negedge MCLK);
         k++;
         h = (DIGIT_OUT === dig && BLINK_PHASE === ph) ? h + 1 : 0;
      end
      if (k >= 20000) chk("digit wait", 16'h0, 16'h1);
   endtask

   task automatic show(input logic [2:0] d, input logic [7:0] p, a);
      wait_for(8'h01 << d, 1'b0);
      chk("seg phase0", {8'h0, SEG_OUT}, {8'h0, p});
      wait_for(8'h01 << d, 1'b1);
      chk("seg phase1", {8'h0, SEG_OUT}, {8'h0, a});
   endtask

   // digit select may only be blank or the allowed pattern
   task automatic watch(input logic [7:0] ok, input int cyc, string nm);
      logic bad;
      bad = 1'b0;
      repeat (cyc) begin
         @(negedge MCLK);
         if (DIGIT_OUT !== 8'h00 && DIGIT_OUT !== ok) bad = 1'b1;
      end
      chk(nm, {15'h0, bad}, 16'h0);
   endtask

   task automatic period(output int c);
      c = 0;
      while (BLINK_PHASE !== 1'b0) @(negedge MCLK);
      while (BLINK_PHASE !== 1'b1) @(negedge MCLK);
      while (BLINK_PHASE === 1'b1 && c < 1000) begin
         @(negedge MCLK);
         c++;
      end
   endtask

   initial begin
      repeat (90000) @(posedge MCLK);
      n_fail++;
      test_done();
   end

   initial begin
      rows = '{'{8'h60, 8'h81, 3'h0, 8'h81, 8'h81},
               '{8'h21, 8'h3c, 3'h1, 8'h3c, 8'h00},
               '{8'h42, 8'h55, 3'h2, 8'h00, 8'h55},
               '{8'h22, 8'ha0, 3'h2, 8'ha0, 8'h55}};
      repeat (20) @(posedge MCLK);
      SYS_RST <= 1'b0;
      @(negedge MCLK);
      chk("reset digit", {8'h0, DIGIT_OUT}, 16'h0);
      chk("reset phase", {15'h0, BLINK_PHASE}, 16'h0);
      host_serial_model_i.send(8'h60, 8'hff);
      watch(8'h00, 2000, "shutdown");
      $display("test reset done");
      host_serial_model_i.send(ADDR_SCAN_LIMIT, 8'h02);
      host_serial_model_i.send(ADDR_CONFIG, 8'h09);
      foreach (rows[i]) begin
         host_serial_model_i.send(rows[i].addr, rows[i].data);
         show(rows[i].dig, rows[i].prim, rows[i].alt);
      end
      $display("test planes done");
      period(n);
      chk("slow half", n[15:0], 16'(2 * BLINK_T));
      host_serial_model_i.send(ADDR_CONFIG, 8'h0d);
      period(n);
      chk("fast half", n[15:0], 16'(BLINK_T));
      host_serial_model_i.send(ADDR_CONFIG, 8'h01);
      show(3'h2, 8'ha0, 8'ha0);
      $display("test rate done");
      host_serial_model_i.send(ADDR_TEST, 8'h01);
      wait_for(8'h80, 1'b0);
      chk("test seg", {8'h0, SEG_OUT}, 16'h00ff);
      host_serial_model_i.send(ADDR_TEST, 8'hfe);
      show(3'h1, 8'h3c, 8'h3c);
      $display("test display test done");
      while (BLINK_PHASE !== 1'b1) @(negedge MCLK);
      host_serial_model_i.send(ADDR_CONFIG, 8'h19);
      @(negedge MCLK);
      chk("sync phase", {15'h0, BLINK_PHASE}, 16'h0);
      chk("sync scan", {13'h0, SCAN_DIGIT}, 16'h0);
      host_serial_model_i.send(ADDR_CONFIG, 8'h29);
      show(3'h0, 8'h00, 8'h00);
      $display("test sync clear done");
      host_serial_model_i.send(ADDR_SCAN_LIMIT, 8'hf8);
      repeat (1700) @(negedge MCLK);
      watch(8'h01, 3500, "scan limit");
      $display("test scan limit done");
      @(posedge MCLK);
      SYS_RST <= 1'b1;
      repeat (2) @(posedge MCLK);
      SYS_RST <= 1'b0;
      @(negedge MCLK);
      chk("rerun digit", {8'h0, DIGIT_OUT}, 16'h0);
      chk("rerun scan", {13'h0, SCAN_DIGIT}, 16'h0);
      chk("rerun phase", {15'h0, BLINK_PHASE}, 16'h0);
      watch(8'h00, 200, "rerun blank");
      $display("test mid reset done");
      test_done();
   end
endmodule
